/* include/gp_timer_pkg.sv */
// Shared constants, register map and mode encodings of the dual-half general timer.
package gp_timer_pkg;
	// Clock and real-time-clock tick rate.
	localparam int CLK_HZ      = 125_000_000;
	localparam int RTC_HZ      = 1;
	localparam int RTC_DIV_DEF = CLK_HZ / RTC_HZ;

	// Widths.
	localparam int AW   = 8;
	localparam int DW   = 32;
	localparam int HW   = 16;
	localparam int PW   = 8;
	localparam int NIRQ = 7;

	// Register byte offsets.
	localparam logic [AW-1:0] OFF_CFG      = 8'h00;
	localparam logic [AW-1:0] OFF_A_MODE   = 8'h04;
	localparam logic [AW-1:0] OFF_B_MODE   = 8'h08;
	localparam logic [AW-1:0] OFF_CTL      = 8'h0C;
	localparam logic [AW-1:0] OFF_IMASK    = 8'h10;
	localparam logic [AW-1:0] OFF_IRAW     = 8'h14;
	localparam logic [AW-1:0] OFF_IMSK_ST  = 8'h18;
	localparam logic [AW-1:0] OFF_ICLR     = 8'h1C;
	localparam logic [AW-1:0] OFF_A_LOAD   = 8'h20;
	localparam logic [AW-1:0] OFF_B_LOAD   = 8'h24;
	localparam logic [AW-1:0] OFF_A_MATCH  = 8'h28;
	localparam logic [AW-1:0] OFF_B_MATCH  = 8'h2C;
	localparam logic [AW-1:0] OFF_A_PRE    = 8'h30;
	localparam logic [AW-1:0] OFF_B_PRE    = 8'h34;
	localparam logic [AW-1:0] OFF_A_PMATCH = 8'h38;
	localparam logic [AW-1:0] OFF_B_PMATCH = 8'h3C;
	localparam logic [AW-1:0] OFF_A_VALUE  = 8'h40;
	localparam logic [AW-1:0] OFF_B_VALUE  = 8'h44;
	localparam logic [AW-1:0] OFF_A_CAPT   = 8'h48;
	localparam logic [AW-1:0] OFF_B_CAPT   = 8'h4C;

	// Field positions inside the half mode registers and the control register.
	localparam int MODE_LSB = 0;
	localparam int MODE_W   = 3;
	localparam int INV_BIT  = 3;
	localparam int EDGE_LSB = 4;
	localparam int HMODE_W  = 6;
	localparam int CFG_W    = 3;
	localparam int CTL_W    = 3;
	localparam int EN_A_BIT = 0;
	localparam int EN_B_BIT = 1;
	localparam int RTC_BIT  = 2;

	// Interrupt source bit positions.
	localparam int IRQ_A_TIMEOUT = 0;
	localparam int IRQ_A_CMATCH  = 1;
	localparam int IRQ_A_CEVENT  = 2;
	localparam int IRQ_RTC       = 3;
	localparam int IRQ_B_TIMEOUT = 4;
	localparam int IRQ_B_CMATCH  = 5;
	localparam int IRQ_B_CEVENT  = 6;

	// Whole-module configuration.
	typedef enum logic [2:0] {
		CFG_32_OS  = 3'b000,
		CFG_32_PER = 3'b001,
		CFG_32_RTC = 3'b011,
		CFG_PAIR16 = 3'b100
	} cfg_mode_t;

	// Operating mode of one half.
	typedef enum logic [2:0] {
		HM_ONESHOT   = 3'b000,
		HM_PERIODIC  = 3'b001,
		HM_CAP_COUNT = 3'b010,
		HM_CAP_TIME  = 3'b011,
		HM_PWM       = 3'b100,
		HM_RTC       = 3'b101
	} half_mode_t;

	// Capture edge selection.
	typedef enum logic [1:0] {
		EDGE_POS  = 2'b00,
		EDGE_NEG  = 2'b01,
		EDGE_BOTH = 2'b11
	} edge_sel_t;
endpackage : gp_timer_pkg

/* design/capture_edge.sv */
// Capture pin synchroniser with selectable edge detection.
`timescale 1ns/1ps
module capture_edge (
	input  wire logic                    clk_i,
	input  wire logic                    rst_i,
	input  wire logic                    pin_i,
	input  wire gp_timer_pkg::edge_sel_t sel_i,
	output logic                         evt_o
);
	import gp_timer_pkg::*;

	logic sync1_r;
	logic sync2_r;
	logic last_r;

	// The first stage only feeds the second; edges are taken from stage two onward.
	wire rise = sync2_r & ~last_r;
	wire fall = ~sync2_r & last_r;
	wire hit  = (sel_i == EDGE_POS) ? rise :
	            (sel_i == EDGE_NEG) ? fall :
	            (sel_i == EDGE_BOTH) ? (rise | fall) : 1'b0;

	// Pin synchroniser and registered edge pulse.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync1_r <= 1'b0;
			sync2_r <= 1'b0;
			last_r  <= 1'b0;
			evt_o   <= 1'b0;
		end else begin
			sync1_r <= pin_i;
			sync2_r <= sync1_r;
			last_r  <= sync2_r;
			evt_o   <= hit;
		end
	end
endmodule : capture_edge

/* design/half_counter.sv */
// One counting half: timer, capture, PWM and real-time-clock behaviour.
`timescale 1ns/1ps
module half_counter #(
	parameter int W = 32
) (
	input  wire logic                     clk_i,
	input  wire logic                     rst_i,
	input  wire logic                     run_i,
	input  wire logic                     start_i,
	input  wire logic                     load_wr_i,
	input  wire logic                     tick_i,
	input  wire gp_timer_pkg::half_mode_t mode_i,
	input  wire logic [W-1:0]             load_i,
	input  wire logic [W-1:0]             match_i,
	input  wire logic                     ext_eq_i,
	input  wire logic                     edge_i,
	output logic      [W-1:0]             cnt_o,
	output logic      [W-1:0]             capt_o,
	output logic                          timeout_o,
	output logic                          match_o,
	output logic                          event_o,
	output logic                          pwm_o
);
	import gp_timer_pkg::*;

	localparam logic [W-1:0] ONE = W'(1);

	logic fired_r;
	logic eq_q_r;

	wire [W-1:0] dec     = cnt_o - ONE;
	wire [W-1:0] inc     = cnt_o + ONE;
	wire         at_zero = (cnt_o == '0);
	// Equality is edge detected so a held count raises only one match pulse.
	wire         eq_now  = (cnt_o == match_i) & ext_eq_i;
	wire         cmp_md  = (mode_i == HM_PERIODIC) | (mode_i == HM_PWM) |
	                       (mode_i == HM_CAP_COUNT) | (mode_i == HM_RTC);
	wire         hit     = run_i & cmp_md & eq_now & ~eq_q_r;

	// Counter, capture latch and event pulses.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_o     <= '0;
			capt_o    <= '0;
			timeout_o <= 1'b0;
			match_o   <= 1'b0;
			event_o   <= 1'b0;
			pwm_o     <= 1'b0;
			fired_r   <= 1'b0;
			eq_q_r    <= 1'b0;
		end else begin
			timeout_o <= 1'b0;
			event_o   <= 1'b0;
			eq_q_r    <= eq_now;
			match_o   <= hit;
			if (hit) begin
				pwm_o <= 1'b0;
			end
			if (load_wr_i || start_i) begin
				cnt_o   <= load_i;
				fired_r <= 1'b0;
				pwm_o   <= 1'b1;
			end else if (run_i) begin
				unique case (mode_i)
					HM_ONESHOT: begin
						if (tick_i && !fired_r) begin
							if (at_zero) begin
								timeout_o <= 1'b1;
								fired_r   <= 1'b1;
							end else begin
								cnt_o <= dec;
							end
						end
					end
					HM_PERIODIC, HM_PWM: begin
						if (tick_i) begin
							if (at_zero) begin
								timeout_o <= 1'b1;
								cnt_o     <= load_i;
								pwm_o     <= 1'b1;
							end else begin
								cnt_o <= dec;
							end
						end
					end
					HM_CAP_COUNT: begin
						if (edge_i) begin
							cnt_o   <= dec;
							event_o <= 1'b1;
						end
					end
					HM_CAP_TIME: begin
						if (tick_i) begin
							cnt_o <= at_zero ? load_i : dec;
						end
						if (edge_i) begin
							capt_o  <= cnt_o;
							event_o <= 1'b1;
						end
					end
					HM_RTC: begin
						if (tick_i) begin
							cnt_o <= inc;
						end
					end
					default: begin
					end
				endcase
			end
		end
	end
endmodule : half_counter

/* design/dual_half_general_timer.sv */
// Dual-half general timer with classic Wishbone register slave and one interrupt line.
`timescale 1ns/1ps
module dual_half_general_timer #(
	parameter int RTC_DIV = gp_timer_pkg::RTC_DIV_DEF
) (
	input  wire logic                         clk_i,
	input  wire logic                         rst_i,
	input  wire logic                         wb_cyc_i,
	input  wire logic                         wb_stb_i,
	input  wire logic                         wb_we_i,
	input  wire logic [gp_timer_pkg::AW-1:0]  wb_adr_i,
	input  wire logic [3:0]                   wb_sel_i,
	input  wire logic [gp_timer_pkg::DW-1:0]  wb_dat_i,
	output logic      [gp_timer_pkg::DW-1:0]  wb_dat_o,
	output logic                              wb_ack_o,
	input  wire logic                         cap_a_i,
	input  wire logic                         cap_b_i,
	output logic                              pwm_a_o,
	output logic                              pwm_b_o,
	output logic                              irq_o
);
	import gp_timer_pkg::*;

	localparam logic [PW-1:0] PRE_ZERO = '0;
	localparam logic [26:0]   RTC_LAST = 27'(RTC_DIV - 1);

	// Software-visible state.
	logic [CFG_W-1:0]   cfg_r;
	logic [HMODE_W-1:0] amode_r;
	logic [HMODE_W-1:0] bmode_r;
	logic [CTL_W-1:0]   ctl_r;
	logic [NIRQ-1:0]    imask_r;
	logic [NIRQ-1:0]    iraw_r;
	logic [DW-1:0]      load_a_r;
	logic [HW-1:0]      load_b_r;
	logic [DW-1:0]      match_a_r;
	logic [HW-1:0]      match_b_r;
	logic [PW-1:0]      pre_a_r;
	logic [PW-1:0]      pre_b_r;
	logic [PW-1:0]      pmatch_a_r;
	logic [PW-1:0]      pmatch_b_r;

	// Internal state.
	logic [PW-1:0]      pcnt_a_r;
	logic [PW-1:0]      pcnt_b_r;
	logic [26:0]        rtc_div_r;
	logic               run_a_q_r;
	logic               run_b_q_r;
	logic               ldw_a_r;
	logic               ldw_b_r;

	// Half outputs.
	logic [DW-1:0]      cnt_a;
	logic [DW-1:0]      capt_a;
	logic [HW-1:0]      cnt_b;
	logic [HW-1:0]      capt_b;
	logic               tmo_a;
	logic               tmo_b;
	logic               mat_a;
	logic               mat_b;
	logic               evt_a;
	logic               evt_b;
	logic               lvl_a;
	logic               lvl_b;
	logic               edge_a;
	logic               edge_b;

	// Bus request decode; one access is taken per cycle in which ack is low.
	wire            req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire            wr    = req & wb_we_i;
	wire [AW-1:0]   wadr  = {wb_adr_i[AW-1:2], 2'b00};
	wire [DW-1:0]   bmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
	                         {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	wire [DW-1:0]   wbits = wb_dat_i & bmask;

	// Per-register write strobes.
	wire w_cfg    = wr & (wadr == OFF_CFG);
	wire w_amode  = wr & (wadr == OFF_A_MODE);
	wire w_bmode  = wr & (wadr == OFF_B_MODE);
	wire w_ctl    = wr & (wadr == OFF_CTL);
	wire w_imask  = wr & (wadr == OFF_IMASK);
	wire w_iclr   = wr & (wadr == OFF_ICLR);
	wire w_load_a = wr & (wadr == OFF_A_LOAD);
	wire w_load_b = wr & (wadr == OFF_B_LOAD);
	wire w_mat_a  = wr & (wadr == OFF_A_MATCH);
	wire w_mat_b  = wr & (wadr == OFF_B_MATCH);
	wire w_pre_a  = wr & (wadr == OFF_A_PRE);
	wire w_pre_b  = wr & (wadr == OFF_B_PRE);
	wire w_pm_a   = wr & (wadr == OFF_A_PMATCH);
	wire w_pm_b   = wr & (wadr == OFF_B_PMATCH);

	// Byte-lane merge of a write into the current register contents; callers cut it to width.
	function automatic logic [DW-1:0] merge(input logic [DW-1:0] old);
		merge = (old & ~bmask) | wbits;
	endfunction : merge

	// Effective modes; in 32-bit configurations half A follows the module mode.
	wire        cfg_ok  = (cfg_r == CFG_32_OS) | (cfg_r == CFG_32_PER) |
	                      (cfg_r == CFG_32_RTC) | (cfg_r == CFG_PAIR16);
	wire        pair    = (cfg_r == CFG_PAIR16);
	wire        rtc_md  = (cfg_r == CFG_32_RTC);
	half_mode_t sw_a;
	half_mode_t sw_b;
	half_mode_t mode_a;
	half_mode_t mode_b;
	assign sw_a   = half_mode_t'(amode_r[MODE_LSB +: MODE_W]);
	assign sw_b   = half_mode_t'(bmode_r[MODE_LSB +: MODE_W]);
	assign mode_a = pair ? sw_a : rtc_md ? HM_RTC :
	                (cfg_r == CFG_32_PER) ? HM_PERIODIC : HM_ONESHOT;
	assign mode_b = sw_b;

	// Run enables; half B is idle in 32-bit configurations.
	wire run_a = ctl_r[EN_A_BIT] & cfg_ok & (~rtc_md | ctl_r[RTC_BIT]);
	wire run_b = ctl_r[EN_B_BIT] & pair;
	wire start_a = run_a & ~run_a_q_r;
	wire start_b = run_b & ~run_b_q_r;

	// Prescaler only matters for paired halves in timing or PWM modes.
	wire use_pre_a = pair & ((mode_a == HM_ONESHOT) | (mode_a == HM_PERIODIC) |
	                         (mode_a == HM_PWM));
	wire use_pre_b = pair & ((mode_b == HM_ONESHOT) | (mode_b == HM_PERIODIC) |
	                         (mode_b == HM_PWM));
	wire rtc_tick  = (rtc_div_r == RTC_LAST);
	wire tick_a    = rtc_md ? rtc_tick : (~use_pre_a | (pcnt_a_r == PRE_ZERO));
	wire tick_b    = ~use_pre_b | (pcnt_b_r == PRE_ZERO);
	wire xeq_a     = ~use_pre_a | (pcnt_a_r == pmatch_a_r);
	wire xeq_b     = ~use_pre_b | (pcnt_b_r == pmatch_b_r);

	// Half A sees only the low half of its values in paired mode.
	wire [DW-1:0] ld_a = pair ? {{HW{1'b0}}, load_a_r[HW-1:0]} : load_a_r;
	wire [DW-1:0] mt_a = pair ? {{HW{1'b0}}, match_a_r[HW-1:0]} : match_a_r;

	// Interrupt sources; each is a one-cycle pulse from its half.
	wire [NIRQ-1:0] iset = {
		evt_b,
		mat_b & (mode_b == HM_CAP_COUNT),
		tmo_b,
		mat_a & rtc_md,
		evt_a,
		mat_a & (mode_a == HM_CAP_COUNT),
		tmo_a
	};
	wire [NIRQ-1:0] iclr = w_iclr ? wbits[NIRQ-1:0] : '0;
	wire [NIRQ-1:0] imsk = iraw_r & imask_r;

	// Read data selection; unmapped addresses read as zero.
	wire [DW-1:0] rd =
		(wadr == OFF_CFG)      ? DW'(cfg_r) :
		(wadr == OFF_A_MODE)   ? DW'(amode_r) :
		(wadr == OFF_B_MODE)   ? DW'(bmode_r) :
		(wadr == OFF_CTL)      ? DW'(ctl_r) :
		(wadr == OFF_IMASK)    ? DW'(imask_r) :
		(wadr == OFF_IRAW)     ? DW'(iraw_r) :
		(wadr == OFF_IMSK_ST)  ? DW'(imsk) :
		(wadr == OFF_A_LOAD)   ? load_a_r :
		(wadr == OFF_B_LOAD)   ? DW'(load_b_r) :
		(wadr == OFF_A_MATCH)  ? match_a_r :
		(wadr == OFF_B_MATCH)  ? DW'(match_b_r) :
		(wadr == OFF_A_PRE)    ? DW'(pre_a_r) :
		(wadr == OFF_B_PRE)    ? DW'(pre_b_r) :
		(wadr == OFF_A_PMATCH) ? DW'(pmatch_a_r) :
		(wadr == OFF_B_PMATCH) ? DW'(pmatch_b_r) :
		(wadr == OFF_A_VALUE)  ? cnt_a :
		(wadr == OFF_B_VALUE)  ? DW'(cnt_b) :
		(wadr == OFF_A_CAPT)   ? capt_a :
		(wadr == OFF_B_CAPT)   ? DW'(capt_b) : '0;

	// Bus answer: ack one cycle after the request, dropped the cycle after.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else begin
			wb_ack_o <= req;
			wb_dat_o <= (req & ~wb_we_i) ? rd : '0;
		end
	end

	// Configuration, value and mask registers.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg_r      <= '0;
			amode_r    <= '0;
			bmode_r    <= '0;
			imask_r    <= '0;
			load_a_r   <= '0;
			load_b_r   <= '0;
			match_a_r  <= '0;
			match_b_r  <= '0;
			pre_a_r    <= '0;
			pre_b_r    <= '0;
			pmatch_a_r <= '0;
			pmatch_b_r <= '0;
		end else begin
			if (w_cfg)    cfg_r      <= CFG_W'(merge(DW'(cfg_r)));
			if (w_amode)  amode_r    <= HMODE_W'(merge(DW'(amode_r)));
			if (w_bmode)  bmode_r    <= HMODE_W'(merge(DW'(bmode_r)));
			if (w_imask)  imask_r    <= NIRQ'(merge(DW'(imask_r)));
			if (w_load_a) load_a_r   <= merge(load_a_r);
			if (w_load_b) load_b_r   <= HW'(merge(DW'(load_b_r)));
			if (w_mat_a)  match_a_r  <= merge(match_a_r);
			if (w_mat_b)  match_b_r  <= HW'(merge(DW'(match_b_r)));
			if (w_pre_a)  pre_a_r    <= PW'(merge(DW'(pre_a_r)));
			if (w_pre_b)  pre_b_r    <= PW'(merge(DW'(pre_b_r)));
			if (w_pm_a)   pmatch_a_r <= PW'(merge(DW'(pmatch_a_r)));
			if (w_pm_b)   pmatch_b_r <= PW'(merge(DW'(pmatch_b_r)));
		end
	end

	// Run control; a finished one-shot half clears its own enable.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctl_r     <= '0;
			run_a_q_r <= 1'b0;
			run_b_q_r <= 1'b0;
		end else begin
			run_a_q_r <= run_a;
			run_b_q_r <= run_b;
			if (w_ctl) begin
				ctl_r <= CTL_W'(merge(DW'(ctl_r)));
			end else begin
				if (tmo_a && mode_a == HM_ONESHOT) ctl_r[EN_A_BIT] <= 1'b0;
				if (tmo_b && mode_b == HM_ONESHOT) ctl_r[EN_B_BIT] <= 1'b0;
			end
		end
	end

	// Load writes to a running half reach the counter one cycle later, once the register holds them.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ldw_a_r <= 1'b0;
			ldw_b_r <= 1'b0;
		end else begin
			ldw_a_r <= w_load_a & run_a;
			ldw_b_r <= w_load_b & run_b;
		end
	end

	// Prescale counters reload from the prescale value each time they expire.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pcnt_a_r <= '0;
			pcnt_b_r <= '0;
		end else begin
			if (start_a || !use_pre_a || !run_a) pcnt_a_r <= pre_a_r;
			else pcnt_a_r <= tick_a ? pre_a_r : pcnt_a_r - PW'(1);
			if (start_b || !use_pre_b || !run_b) pcnt_b_r <= pre_b_r;
			else pcnt_b_r <= tick_b ? pre_b_r : pcnt_b_r - PW'(1);
		end
	end

	// Real-time-clock divider; it idles outside the enabled clock mode.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rtc_div_r <= '0;
		end else if (!(rtc_md && run_a) || rtc_tick) begin
			rtc_div_r <= '0;
		end else begin
			rtc_div_r <= rtc_div_r + 27'(1);
		end
	end

	// Sticky interrupt status; a new event in the clear cycle survives the clear.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			iraw_r <= '0;
			irq_o  <= 1'b0;
		end else begin
			iraw_r <= (iraw_r & ~iclr) | iset;
			irq_o  <= |imsk;
		end
	end

	// Output pins take the polarity chosen per half.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pwm_a_o <= 1'b0;
			pwm_b_o <= 1'b0;
		end else begin
			pwm_a_o <= (mode_a == HM_PWM) & run_a & (lvl_a ^ amode_r[INV_BIT]);
			pwm_b_o <= (mode_b == HM_PWM) & run_b & (lvl_b ^ bmode_r[INV_BIT]);
		end
	end

	// Capture pin edge detectors.
	capture_edge u_edge_a (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.pin_i (cap_a_i),
		.sel_i (edge_sel_t'(amode_r[EDGE_LSB +: 2])),
		.evt_o (edge_a)
	);

	capture_edge u_edge_b (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.pin_i (cap_b_i),
		.sel_i (edge_sel_t'(bmode_r[EDGE_LSB +: 2])),
		.evt_o (edge_b)
	);

	// Half A carries the full 32-bit count in the wide configurations.
	half_counter #(.W(DW)) u_half_a (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.run_i     (run_a),
		.start_i   (start_a),
		.load_wr_i (ldw_a_r),
		.tick_i    (tick_a),
		.mode_i    (mode_a),
		.load_i    (ld_a),
		.match_i   (mt_a),
		.ext_eq_i  (xeq_a),
		.edge_i    (edge_a & pair),
		.cnt_o     (cnt_a),
		.capt_o    (capt_a),
		.timeout_o (tmo_a),
		.match_o   (mat_a),
		.event_o   (evt_a),
		.pwm_o     (lvl_a)
	);

	half_counter #(.W(HW)) u_half_b (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.run_i     (run_b),
		.start_i   (start_b),
		.load_wr_i (ldw_b_r),
		.tick_i    (tick_b),
		.mode_i    (mode_b),
		.load_i    (load_b_r),
		.match_i   (match_b_r),
		.ext_eq_i  (xeq_b),
		.edge_i    (edge_b),
		.cnt_o     (cnt_b),
		.capt_o    (capt_b),
		.timeout_o (tmo_b),
		.match_o   (mat_b),
		.event_o   (evt_b),
		.pwm_o     (lvl_b)
	);
endmodule : dual_half_general_timer

/* verification/cpu_model.sv */
// Processor-side model that reaches the timer registers over classic Wishbone.
`timescale 1ns/1ps
module cpu_model (
	input  wire logic        clk_i,
	output logic             cyc_o,
	output logic             stb_o,
	output logic             we_o,
	output logic [7:0]       adr_o,
	output logic [3:0]       sel_o,
	output logic [31:0]      dat_o,
	input  wire logic [31:0] dat_i,
	input  wire logic        ack_i
);
	// The bus rests idle until the first request.
	initial begin
		cyc_o = 1'b0;
		stb_o = 1'b0;
		we_o  = 1'b0;
		adr_o = 8'h00;
		sel_o = 4'hF;
		dat_o = 32'h0;
	end

	// One cycle held until ack; released lines show inverted data, not stale data.
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk_i);
		cyc_o <= 1'b1;
		stb_o <= 1'b1;
		we_o  <= w;
		adr_o <= a;
		dat_o <= d;
		do @(posedge clk_i); while (ack_i !== 1'b1);
		q = dat_i;
		cyc_o <= 1'b0;
		stb_o <= 1'b0;
		adr_o <= ~a;
		dat_o <= ~d;
	endtask : xfer
endmodule : cpu_model

/* verification/timer_monitor.sv */
// Concurrent checks on the timer's bus and interrupt ports.
`timescale 1ns/1ps
module timer_monitor (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        pwm_a_o,
	input wire logic        pwm_b_o,
	input wire logic        irq_o
);
	import gp_timer_pkg::*;
	// A request is taken at an edge where it is up and not yet answered.
	wire take  = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire mask0 = take && wb_we_i && wb_adr_i == OFF_IMASK && wb_dat_i[6:0] == 7'h00;
	wire st_rd = wb_ack_o && !wb_we_i && wb_adr_i inside {OFF_IMASK, OFF_IRAW, OFF_IMSK_ST};
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	ack_delay_a: assert property (take |=> wb_ack_o) else $error("ack late");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
	ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	dat_quiet_a: assert property ((!wb_ack_o || wb_we_i) |-> wb_dat_o == 32'h0)
		else $error("read data outside read ack");
	reset_quiet_a: assert property ($fell(rst_i) |-> !(irq_o || pwm_a_o || pwm_b_o || wb_ack_o))
		else $error("output up after reset");
	mask_off_a: assert property (mask0 |-> ##2 !irq_o [*2])
		else $error("masked source still drives irq");
	irq_fall_a: assert property ($fell(irq_o) |-> $past(take && wb_we_i, 2))
		else $error("irq fell without a write");
	status_width_a: assert property (st_rd |-> wb_dat_o[31:7] == 25'h0)
		else $error("status wider than seven sources");
	unmapped_zero_a: assert property (wb_ack_o && wb_adr_i > 8'h4F |-> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
endmodule : timer_monitor

bind dual_half_general_timer timer_monitor mon (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
	.wb_we_i, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .pwm_a_o, .pwm_b_o, .irq_o);

/* verification/testbench.sv */
// Self-checking bench: register readback, interrupts, reload, RTC, edge count and PWM.
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
	import gp_timer_pkg::*;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc, stb, we, ack, pwm_a, pwm_b, irq_o;
	logic        cap_a = 1'b0;
	logic        cap_b = 1'b0;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [31:0] wdat, rdat, q, v;
	edge_sel_t   es [3] = '{EDGE_POS, EDGE_NEG, EDGE_BOTH};
	int          hi [3];
	int          n_mismatch = 0;
	int          n_tests = 0;

	// Free-running 125 MHz clock.
	always #4 clk_i = ~clk_i;

	dual_half_general_timer #(.RTC_DIV(4)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .cap_a_i(cap_a), .cap_b_i(cap_b),
		.pwm_a_o(pwm_a), .pwm_b_o(pwm_b), .irq_o(irq_o));
	cpu_model cpu (.clk_i(clk_i), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr),
		.sel_o(sel), .dat_o(wdat), .dat_i(rdat), .ack_i(ack));

	task complete_run();
		$display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : complete_run

	task wr(input logic [7:0] a, input logic [31:0] d);
		cpu.xfer(1'b1, a, d, q);
	endtask : wr

	task rd_chk(input logic [7:0] a, input logic [31:0] e);
		cpu.xfer(1'b0, a, 32'h0, q);
		`CHK(q, e)
	endtask : rd_chk

	// Bounded wait so a silent interrupt shows as a mismatch, not a hang.
	task wait_irq();
		for (int i = 0; i < 80 && irq_o !== 1'b1; i++) @(posedge clk_i);
	endtask : wait_irq

	// One capture pulse, long enough to pass the two-flop synchroniser.
	task pulse_b();
		cap_b <= 1'b1;
		repeat (4) @(posedge clk_i);
		cap_b <= 1'b0;
		repeat (4) @(posedge clk_i);
	endtask : pulse_b

	// Counter after n pulses from a load of ten; both edges count twice per pulse.
	function logic [31:0] exp_cnt(input edge_sel_t e, input int n);
		return 32'(10 - n * (e == EDGE_BOTH ? 2 : 1));
	endfunction : exp_cnt

	// Half B event is always set; match only once the count has reached six.
	function logic [31:0] exp_raw_b(input logic [31:0] c);
		return {25'h0, 1'b1, c == 32'd6, 5'h0};
	endfunction : exp_raw_b

	// Watchdog well above the expected run length.
	initial begin
		repeat (20000) @(posedge clk_i);
		n_mismatch++;
		complete_run();
	end

	// Main sequence.
	initial begin
		v = $urandom(32'hB751);
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		wr(OFF_CFG, 32'(CFG_PAIR16));
		for (int o = 8'h20; o < 8'h40; o += 4) begin
			v = $urandom & (o < 8'h30 ? 32'hFFFF : 32'hFF);
			wr(8'(o), v);
			rd_chk(8'(o), v);
		end
		wr(8'h80, $urandom);
		rd_chk(8'h80, 32'h0);
		wr(OFF_IMASK, 32'hFFFFFFFF);
		rd_chk(OFF_IMASK, 32'h7F);
		wr(OFF_IMASK, 32'h0);
		// One-shot timeout, then mask off, mask on and clear.
		wr(OFF_CFG, 32'(CFG_32_OS));
		wr(OFF_A_LOAD, 32'h5);
		wr(OFF_IMASK, 32'h1);
		wr(OFF_CTL, 32'h1);
		wait_irq();
		`CHK(irq_o, 1'b1)
		wr(OFF_IMASK, 32'h0);
		rd_chk(OFF_IMSK_ST, 32'h0);
		`CHK(irq_o, 1'b0)
		rd_chk(OFF_IRAW, 32'h1);
		wr(OFF_IMASK, 32'h1);
		wr(OFF_ICLR, 32'h1);
		rd_chk(OFF_IRAW, 32'h0);
		`CHK(irq_o, 1'b0)
		// A short load written mid-interval must take effect at once.
		wr(OFF_CFG, 32'(CFG_32_PER));
		wr(OFF_A_LOAD, 32'h00FF0000);
		wr(OFF_CTL, 32'h1);
		repeat (20) @(posedge clk_i);
		`CHK(irq_o, 1'b0)
		wr(OFF_A_LOAD, 32'h4);
		wait_irq();
		// The random prescale value left in half A must not slow a 32-bit count.
		`CHK(irq_o, 1'b1)
		wr(OFF_CTL, 32'h0);
		wr(OFF_ICLR, 32'h7F);
		// Real-time-clock match.
		wr(OFF_CFG, 32'(CFG_32_RTC));
		wr(OFF_A_LOAD, 32'h0);
		wr(OFF_A_MATCH, 32'h3);
		wr(OFF_IMASK, 32'h8);
		wr(OFF_CTL, 32'h5);
		wait_irq();
		rd_chk(OFF_IMSK_ST, 32'h8);
		wr(OFF_CTL, 32'h0);
		wr(OFF_ICLR, 32'h7F);
		// Edge count on half B for every edge selection.
		wr(OFF_CFG, 32'(CFG_PAIR16));
		for (int k = 0; k < 3; k++) begin
			wr(OFF_B_MODE, {26'h0, es[k], 1'b0, HM_CAP_COUNT});
			wr(OFF_B_LOAD, 32'd10);
			wr(OFF_B_MATCH, 32'd6);
			wr(OFF_ICLR, 32'h7F);
			wr(OFF_CTL, 32'h2);
			repeat (2) pulse_b();
			rd_chk(OFF_B_VALUE, exp_cnt(es[k], 2));
			rd_chk(OFF_IRAW, exp_raw_b(exp_cnt(es[k], 2)));
			wr(OFF_CTL, 32'h0);
		end
		// PWM on half A in both polarities; a window of whole periods is compared.
		// The third pass sets a prescale match the prescaler never reaches, so no fall.
		wr(OFF_A_PRE, 32'h0);
		wr(OFF_A_LOAD, 32'd9);
		wr(OFF_A_MATCH, 32'd3);
		for (int i = 0; i < 3; i++) begin
			wr(OFF_A_PMATCH, 32'(i / 2));
			wr(OFF_A_MODE, {28'h0, i[0], HM_PWM});
			wr(OFF_CTL, 32'h1);
			repeat (5) @(posedge clk_i);
			hi[i] = 0;
			repeat (40) begin
				@(posedge clk_i);
				hi[i] += pwm_a;
			end
			wr(OFF_CTL, 32'h0);
		end
		`CHK(32'(hi[0] + hi[1]), 32'd40)
		`CHK(hi[0] inside {[1:39]}, 1'b1)
		`CHK(32'(hi[2]), 32'd40)
		`CHK(pwm_b, 1'b0)
		complete_run();
	end
endmodule : testbench
